// >>> design/wdsl_defs.svh
// Purpose: Offsets, field positions, reset values and keys of the watchdog status/lock block
// Assumes: APB byte addresses, 32-bit data, one aligned word per register
// Notes:   Definitions only
`ifndef WDSL_DEFS_SVH
`define WDSL_DEFS_SVH

`define WDSL_OFF_LOAD      12'h000
`define WDSL_OFF_VALUE     12'h004
`define WDSL_OFF_CTRL      12'h008
`define WDSL_OFF_ICLR      12'h00C
`define WDSL_OFF_RIS       12'h010
`define WDSL_OFF_MIS       12'h014
`define WDSL_OFF_IMASK     12'h018
`define WDSL_OFF_ISTAT     12'h01C
`define WDSL_OFF_TEST      12'h418
`define WDSL_OFF_LOCK      12'hC00
`define WDSL_OFF_ID_LOW    12'hFD0
`define WDSL_OFF_ID_SECOND 12'hFD4

`define WDSL_UNLOCK_KEY    32'h1ACC_E551
`define WDSL_LOAD_RESET    32'hFFFF_FFFF
`define WDSL_LOCKED_VALUE  32'h0000_0001
`define WDSL_UNLOCKED_VAL  32'h0000_0000
`define WDSL_STALL_BIT     8
`define WDSL_CTRL_IRQ_ENABLE 0
`define WDSL_CTRL_RST_ENABLE 1
`define WDSL_EV_TIMEOUT    0
`define WDSL_EV_RESET      1
`define WDSL_EV_W          2

// Identification bytes; values are arbitrary
`define WDSL_ID_LOW_BYTE    8'h5A
`define WDSL_ID_SECOND_BYTE 8'hC3

`endif

// >>> design/wdsl_pkg.sv
// Purpose: Types shared by the watchdog status/lock block
// Assumes: Nothing
// Notes:   Constants live in wdsl_defs.svh
package wdsl_pkg;
  typedef enum logic [1:0] {
    WDSL_IDLE  = 2'b00,
    WDSL_ARMED = 2'b01,
    WDSL_FIRED = 2'b10
  } wdsl_state_t;
endpackage : wdsl_pkg

// >>> design/wdsl_if.sv
// Purpose: Link between register front end and counter core
// Assumes: Single clock
// Notes:   Pulses are one cycle
`timescale 1ns/1ps
`default_nettype none
interface wdsl_if;
  logic        reload;
  logic [31:0] load_value;
  logic        run;
  logic        stall;
  logic        timeout;
  logic [31:0] count;
  modport regs (output reload, output load_value, output run, output stall,
                input timeout, input count);
  modport core (input reload, input load_value, input run, input stall,
                output timeout, output count);
endinterface : wdsl_if
`default_nettype wire

// >>> design/wdsl_counter.sv
// Purpose: 32-bit down counter of the watchdog
// Assumes: reload and timeout are single-cycle pulses
// Notes:   Reload wins over counting
`timescale 1ns/1ps
`default_nettype none
`include "wdsl_defs.svh"
module wdsl_counter (
  // Clock and reset
  input  wire logic clk,
  input  wire logic arst_n,
  // Front end
  wdsl_if.core      lnk
);
  logic [31:0] count;
  logic        timeout;
  wire         at_zero = (count == 32'h0000_0000);
  wire         counting = lnk.run && !lnk.stall;

  assign lnk.count   = count;
  assign lnk.timeout = timeout;

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      count   <= `WDSL_LOAD_RESET;
      timeout <= 1'b0;
    end else begin
      timeout <= 1'b0;
      if (lnk.reload) begin
        count <= lnk.load_value;
      end else if (counting && at_zero) begin
        count   <= lnk.load_value;
        timeout <= 1'b1;
      end else if (counting) begin
        count <= count - 32'h0000_0001;
      end
    end
  end
endmodule : wdsl_counter
`default_nettype wire

// >>> design/wdsl_top.sv
// Purpose: Watchdog status, clear, lock, debug stall and identification registers
// Assumes: APB slave, 100 MHz clk, asynchronous active-low reset
// Notes:   debug_halt comes from another domain and is synchronised
// Operation
// - Any clear write drops interrupt, reloads counter
// - Clear register write-only, reads zero
// - Raw status bit 0 shows unmasked interrupt
// - Masked bit is raw AND interrupt enable
// - Key written to lock unlocks writes
// - Other lock value relocks, blocking writes
// - Lock read returns one locked, zero unlocked
// - Stall bit freezes counter during debug halt
// - Identification registers are constant bytes
// - Reserved bits read zero, software preserves
// - Zero reached: interrupt, reload, keep counting
// - Second zero before clear asserts reset
// - Interrupt enable sticks until hardware reset
`timescale 1ns/1ps
`default_nettype none
`include "wdsl_defs.svh"
module wdsl_top (
  // Clock and reset
  input  wire logic        clk,
  input  wire logic        arst_n,
  // APB slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output var  logic [31:0] prdata,
  output var  logic        pready,
  output var  logic        pslverr,
  // Debug
  input  wire logic        debug_halt,
  // Outputs to the system
  output var  logic        timeout_interrupt,
  output var  logic        system_reset_out,
  output var  logic        irq
);
  wdsl_if lnk ();

  wdsl_counter u_counter (
    .clk    (clk),
    .arst_n (arst_n),
    .lnk    (lnk)
  );

  // Registers
  logic [31:0]                reload_value;
  logic                       interrupt_enable_bit;
  logic                       reset_enable_bit;
  logic                       stall_enable;
  logic                       locked;
  logic                       raw_int;
  logic [`WDSL_EV_W-1:0]      ev_status;
  logic [`WDSL_EV_W-1:0]      ev_mask;
  logic                       reload_pulse;
  logic                       halt_meta;
  logic                       halt_sync;
  wdsl_pkg::wdsl_state_t      state;
  wdsl_pkg::wdsl_state_t      next_state;

  function automatic logic hit(input logic [11:0] a, input logic [11:0] off);
    hit = (a[11:2] == off[11:2]);
  endfunction : hit

  // Bus decode
  wire acc      = psel && penable;
  wire wr       = acc && pwrite;
  wire rd_ok    = !pwrite;
  wire sel_load = hit(paddr, `WDSL_OFF_LOAD);
  wire sel_val  = hit(paddr, `WDSL_OFF_VALUE);
  wire sel_ctrl = hit(paddr, `WDSL_OFF_CTRL);
  wire sel_iclr = hit(paddr, `WDSL_OFF_ICLR);
  wire sel_ris  = hit(paddr, `WDSL_OFF_RIS);
  wire sel_mis  = hit(paddr, `WDSL_OFF_MIS);
  wire sel_imsk = hit(paddr, `WDSL_OFF_IMASK);
  wire sel_ist  = hit(paddr, `WDSL_OFF_ISTAT);
  wire sel_test = hit(paddr, `WDSL_OFF_TEST);
  wire sel_lock = hit(paddr, `WDSL_OFF_LOCK);
  wire sel_id0  = hit(paddr, `WDSL_OFF_ID_LOW);
  wire sel_id1  = hit(paddr, `WDSL_OFF_ID_SECOND);
  wire mapped   = sel_load | sel_val | sel_ctrl | sel_iclr | sel_ris | sel_mis | sel_imsk
                | sel_ist | sel_test | sel_lock | sel_id0 | sel_id1;

  // Writes other than to the lock are suppressed while locked
  wire wr_open  = wr && !locked;
  wire wr_load  = wr_open && sel_load;
  wire wr_ctrl  = wr_open && sel_ctrl && !interrupt_enable_bit;
  wire wr_iclr  = wr_open && sel_iclr;
  wire wr_test  = wr_open && sel_test;
  wire wr_imsk  = wr_open && sel_imsk;
  wire wr_ist   = wr_open && sel_ist;
  wire wr_lock  = wr && sel_lock;
  wire key_ok   = (pwdata == `WDSL_UNLOCK_KEY);
  wire run_on   = wr_ctrl && pwdata[`WDSL_CTRL_IRQ_ENABLE];

  // Counter core link
  assign lnk.load_value = wr_load ? pwdata : reload_value;
  assign lnk.reload     = reload_pulse;
  assign lnk.run        = interrupt_enable_bit;
  assign lnk.stall      = stall_enable && halt_sync;

  // Second time-out detection
  wire second_to = lnk.timeout && raw_int;
  wire fire_rst  = second_to && reset_enable_bit;

  always_comb begin
    next_state = state;
    case (state)
      // State tracks the raw bit: a time-out beats a clear in the same cycle
      wdsl_pkg::WDSL_IDLE: begin
        if (fire_rst) begin
          next_state = wdsl_pkg::WDSL_FIRED;
        end else if (lnk.timeout) begin
          next_state = wdsl_pkg::WDSL_ARMED;
        end
      end
      wdsl_pkg::WDSL_ARMED: begin
        if (fire_rst) begin
          next_state = wdsl_pkg::WDSL_FIRED;
        end else if (wr_iclr && !lnk.timeout) begin
          next_state = wdsl_pkg::WDSL_IDLE;
        end
      end
      wdsl_pkg::WDSL_FIRED: next_state = wdsl_pkg::WDSL_FIRED;
      default:              next_state = wdsl_pkg::WDSL_IDLE;
    endcase
  end

  // Read data; reserved bits read zero, clear register reads zero
  wire [31:0] rd_data =
      sel_load ? reload_value :
      sel_val  ? lnk.count :
      sel_ctrl ? {30'h0, reset_enable_bit, interrupt_enable_bit} :
      sel_ris  ? {31'h0, raw_int} :
      sel_mis  ? {31'h0, raw_int & interrupt_enable_bit} :
      sel_imsk ? {30'h0, ev_mask} :
      sel_ist  ? {30'h0, ev_status} :
      sel_test ? {23'h0, stall_enable, 8'h00} :
      sel_lock ? (locked ? `WDSL_LOCKED_VALUE : `WDSL_UNLOCKED_VAL) :
      sel_id0  ? {24'h0, `WDSL_ID_LOW_BYTE} :
      sel_id1  ? {24'h0, `WDSL_ID_SECOND_BYTE} :
      32'h0000_0000;

  // Events: set wins over write-one-to-clear
  wire [`WDSL_EV_W-1:0] ev_set   = {fire_rst, lnk.timeout};
  wire [`WDSL_EV_W-1:0] ev_clr   = wr_ist ? pwdata[`WDSL_EV_W-1:0] : 2'b00;
  wire [`WDSL_EV_W-1:0] next_ev  = (ev_status & ~ev_clr) | ev_set;

  // Interrupt line: raw set by time-out, cleared by clear write; time-out wins
  wire next_raw = lnk.timeout ? 1'b1 : (wr_iclr ? 1'b0 : raw_int);

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      halt_meta <= 1'b0;
      halt_sync <= 1'b0;
    end else begin
      halt_meta <= debug_halt;
      halt_sync <= halt_meta;
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      reload_value         <= `WDSL_LOAD_RESET;
      interrupt_enable_bit <= 1'b0;
      reset_enable_bit     <= 1'b0;
      stall_enable         <= 1'b0;
      locked               <= 1'b0;
    end else begin
      if (wr_load) begin
        reload_value <= pwdata;
      end
      if (wr_ctrl) begin
        interrupt_enable_bit <= pwdata[`WDSL_CTRL_IRQ_ENABLE];
        reset_enable_bit     <= pwdata[`WDSL_CTRL_RST_ENABLE];
      end
      if (wr_test) begin
        stall_enable <= pwdata[`WDSL_STALL_BIT];
      end
      if (wr_lock) begin
        locked <= !key_ok;
      end
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      raw_int      <= 1'b0;
      reload_pulse <= 1'b0;
      ev_status    <= 2'b00;
      ev_mask      <= 2'b00;
      state        <= wdsl_pkg::WDSL_IDLE;
    end else begin
      raw_int      <= next_raw;
      reload_pulse <= wr_iclr || wr_load || run_on;
      ev_status    <= next_ev;
      state        <= next_state;
      if (wr_imsk) begin
        ev_mask <= pwdata[`WDSL_EV_W-1:0];
      end
    end
  end

  // Outputs, all registered
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      prdata            <= 32'h0000_0000;
      pready            <= 1'b0;
      pslverr           <= 1'b0;
      timeout_interrupt <= 1'b0;
      system_reset_out  <= 1'b0;
      irq               <= 1'b0;
    end else begin
      pready            <= psel && !penable;
      pslverr           <= psel && !penable && !mapped;
      prdata            <= (psel && !penable && rd_ok) ? rd_data : 32'h0000_0000;
      timeout_interrupt <= next_raw && interrupt_enable_bit;
      system_reset_out  <= (next_state == wdsl_pkg::WDSL_FIRED);
      irq               <= |(next_ev & ev_mask);
    end
  end
endmodule : wdsl_top
`default_nettype wire

// >>> verification/wdsl_assertions.sv
// Purpose: Port-level checks of the watchdog register block
// Assumes: One clock, asynchronous active-low reset
// Notes:   Bound to wdsl_top from tb_top
`timescale 1ns/1ps
`default_nettype none
`include "wdsl_defs.svh"
module wdsl_assertions (
  // Clock and reset
  input wire logic        clk,
  input wire logic        arst_n,
  // APB
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr,
  // System outputs
  input wire logic        timeout_interrupt,
  input wire logic        system_reset_out
);
  default clocking @(posedge clk); endclocking
  default disable iff (!arst_n);
  wire rd = pready && !pwrite;
  sequence setup_s; psel && !penable; endsequence
  sequence answer_s; pready ##1 !pready; endsequence
  read_answer_a: assert property (setup_s |=> answer_s)
    else $error("setup not answered by one pready pulse");
  err_pair_a: assert property (pslverr |-> pready)
    else $error("pslverr without pready");
  lock_read_a: assert property (rd && paddr == `WDSL_OFF_LOCK |-> prdata[31:1] == 31'h0)
    else $error("lock read not a status bit");
  // Only the raw and masked status words; the event words next to them use two bits
  res_bits_a: assert property (rd && paddr[11:3] == 9'h002 |-> prdata[31:1] == 31'h0)
    else $error("status reserved bits set");
  id_low_a: assert property (rd && paddr == `WDSL_OFF_ID_LOW |-> prdata[7:0] == `WDSL_ID_LOW_BYTE)
    else $error("identification byte wrong");
  clr_read_a: assert property (rd && paddr == `WDSL_OFF_ICLR |-> prdata == 32'h0)
    else $error("clear register read not zero");
  rst_hold_a: assert property (system_reset_out |=> system_reset_out)
    else $error("system reset dropped");
  rst_cause_a: assert property ($rose(system_reset_out) |-> $past(timeout_interrupt))
    else $error("system reset without pending interrupt");
endmodule : wdsl_assertions
`default_nettype wire

// >>> verification/tb_top.sv
// Purpose: Self-checking bench for the watchdog register block
// Assumes: Zero-wait APB slave, fixed seed
// Notes:   Short load values keep time-outs brief
`timescale 1ns/1ps
`default_nettype none
`include "wdsl_defs.svh"
module tb_top;
  logic        clk = 0, arst_n = 0, psel = 0, penable = 0, pwrite = 0, debug_halt = 0;
  logic [11:0] paddr = 0;
  logic [31:0] pwdata = 0, prdata, rd, ld, v1;
  logic        pready, pslverr, timeout_interrupt, system_reset_out, irq, err;
  int          n_errors = 0, tests_run = 0;
  logic [11:0] ra [5] = '{`WDSL_OFF_RIS, `WDSL_OFF_MIS, `WDSL_OFF_TEST, `WDSL_OFF_ID_LOW,
                          `WDSL_OFF_ID_SECOND};
  logic [31:0] re [5] = '{32'h0000_0000, 32'h0000_0000, 32'h0000_0000,
                          {24'h00_0000, `WDSL_ID_LOW_BYTE}, {24'h00_0000, `WDSL_ID_SECOND_BYTE}};
  always #5 clk = ~clk;
  wdsl_top i_wdsl_top (.clk, .arst_n, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
    .pready, .pslverr, .debug_halt, .timeout_interrupt, .system_reset_out, .irq);
  function automatic logic [31:0] lock_val(input logic locked);
    return {31'h0, locked};
  endfunction : lock_val
  task automatic give_verdict;
    $display("errors %0d checks %0d", n_errors, tests_run);
    if (n_errors == 0 && tests_run > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask : give_verdict
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      n_errors++;
      $display("Error %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  // One APB transfer, held until pready is sampled high
  task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge clk);
    psel <= 1;
    penable <= 0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1;
    // Only the watchdog ends a wait for the answer
    do begin
      @(posedge clk);
    end while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 0;
    penable <= 0;
  endtask : xfer
  task automatic wait_for(input logic which, input int lim);
    int t = 0;
    while ((which ? system_reset_out : timeout_interrupt) !== 1'b1 && t < lim) begin
      @(posedge clk);
      t++;
    end
    if (t >= lim) begin
      n_errors++;
      $display("Error %0t: wait for output ran out", $time);
    end
  endtask : wait_for
  initial begin
    void'($urandom(49185));
    repeat (20) @(posedge clk);
    arst_n <= 1;
    xfer(0, `WDSL_OFF_LOCK, 0);
    chk(rd, lock_val(0));
    foreach (ra[i]) begin
      xfer(0, ra[i], 0);
      chk(rd, re[i]);
    end
    xfer(0, `WDSL_OFF_ICLR, 0);
    chk(err, 0);
    xfer(0, 12'h800, 0);
    chk(err, 1);
    chk(rd, 32'h0000_0000);
    xfer(1, `WDSL_OFF_LOCK, $urandom & 32'hFFFF_0000);
    xfer(0, `WDSL_OFF_LOCK, 0);
    chk(rd, lock_val(1));
    xfer(1, `WDSL_OFF_LOAD, 32'h0000_0040);
    xfer(0, `WDSL_OFF_LOAD, 0);
    chk(rd, `WDSL_LOAD_RESET);
    xfer(1, `WDSL_OFF_LOCK, `WDSL_UNLOCK_KEY);
    xfer(0, `WDSL_OFF_LOCK, 0);
    chk(rd, lock_val(0));
    ld = 32'd60 + ($urandom % 16);
    xfer(1, `WDSL_OFF_LOAD, ld);
    xfer(1, `WDSL_OFF_TEST, 32'hFFFF_FFFF);
    xfer(0, `WDSL_OFF_TEST, 0);
    chk(rd, 32'h0000_0100);
    xfer(1, `WDSL_OFF_CTRL, 32'h3);
    wait_for(0, 200);
    xfer(0, `WDSL_OFF_RIS, 0);
    chk(rd, 1);
    xfer(0, `WDSL_OFF_MIS, 0);
    chk(rd, 1);
    xfer(1, `WDSL_OFF_ICLR, $urandom);
    xfer(0, `WDSL_OFF_VALUE, 0);
    // Without the reload the count would sit about a dozen below the load value
    chk(rd <= ld && rd + 32'd2 >= ld, 1);
    chk(timeout_interrupt, 0);
    xfer(1, `WDSL_OFF_CTRL, 32'h0);
    xfer(0, `WDSL_OFF_CTRL, 0);
    chk(rd & 32'h1, 1);
    xfer(1, `WDSL_OFF_IMASK, 32'h1);
    repeat (2) @(posedge clk);
    chk(irq, 1);
    xfer(1, `WDSL_OFF_ISTAT, 32'h1);
    repeat (2) @(posedge clk);
    chk(irq, 0);
    debug_halt <= 1;
    repeat (4) @(posedge clk);
    xfer(0, `WDSL_OFF_VALUE, 0);
    v1 = rd;
    repeat (10) @(posedge clk);
    xfer(0, `WDSL_OFF_VALUE, 0);
    chk(rd, v1);
    debug_halt <= 0;
    wait_for(1, 400);
    chk(system_reset_out, 1);
    xfer(0, `WDSL_OFF_ISTAT, 0);
    chk(rd, 32'h0000_0003);
    chk(irq, 1);
    // Lock, then a second hardware reset in mid-run
    xfer(1, `WDSL_OFF_LOCK, $urandom & 32'hFFFF_0000);
    @(posedge clk);
    arst_n <= 0;
    repeat (2) @(posedge clk);
    chk(system_reset_out, 0);
    chk(irq, 0);
    arst_n <= 1;
    xfer(0, `WDSL_OFF_LOCK, 0);
    chk(rd, lock_val(0));
    xfer(0, `WDSL_OFF_CTRL, 0);
    chk(rd, 32'h0000_0000);
    xfer(0, `WDSL_OFF_TEST, 0);
    chk(rd, 32'h0000_0000);
    // With the stall bit clear the counter keeps running through a halt
    xfer(1, `WDSL_OFF_CTRL, 32'h0000_0001);
    debug_halt <= 1;
    repeat (4) @(posedge clk);
    xfer(0, `WDSL_OFF_VALUE, 0);
    v1 = rd;
    repeat (10) @(posedge clk);
    xfer(0, `WDSL_OFF_VALUE, 0);
    chk(rd != v1, 1);
    debug_halt <= 0;
    give_verdict();
  end
  initial begin
    #50000;
    n_errors++;
    $display("Error %0t: run hung", $time);
    give_verdict();
  end
endmodule : tb_top
bind wdsl_top wdsl_assertions i_wdsl_assertions (.clk, .arst_n, .psel, .penable, .pwrite,
  .paddr, .prdata, .pready, .pslverr, .timeout_interrupt, .system_reset_out);
`default_nettype wire
